// file: pshc_consts.svh
`ifndef PSHC_CONSTS_SVH
`define PSHC_CONSTS_SVH
// Fixed upper two bits of the serial slave address
`define PSHC_ADDR_PREFIX 2'h1
// Minimum reset pulse in ns and its count at 4 ns clock
`define PSHC_RST_MIN_NS 10000
`define PSHC_CLK_NS 4
`define PSHC_RST_MIN_CYC ((`PSHC_RST_MIN_NS + `PSHC_CLK_NS - 1) / `PSHC_CLK_NS)
// Number of power ports
`define PSHC_PORTS 8
`endif

// file: pshc_pkg.sv
package pshc_pkg;
  // Serial slave states, Gray coded along the usual path
  typedef enum logic [2:0] {
    PSHC_IDLE = 3'h0,
    PSHC_ADDR = 3'h1,
    PSHC_AACK = 3'h3,
    PSHC_DATA = 3'h2,
    PSHC_DACK = 3'h6,
    PSHC_SKIP = 3'h7
  } pshc_state_t;
endpackage

// file: pshc_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for a group of pins
module pshc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pshc_sync_t;
  pshc_sync_t st_reg;
  pshc_sync_t st_next;

  // First stage feeds only the second
  always_comb
  begin
    st_next    = st_reg;
    st_next.s1 = din;
    st_next.s2 = st_reg.s1;
  end

  // Pins idle high through their pull-ups
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      st_reg <= '1;
    else
      st_reg <= st_next;
  end

  assign dout = st_reg.s2;
endmodule

// file: pshc_top.sv
`timescale 1ns/1ps
`include "pshc_consts.svh"

// Overview of operation
// - Active-low device reset holds the embedded controller disabled.
// - During reset all state except the reset counter and flag, pin history, latched straps and mode returns to defaults and ports switch off.
// - Any port fault drives the open-drain interrupt low.
// - Interrupt level changes only between complete serial transactions.
// - Low mode strap selects host control; high selects autonomous mode.
// - Slave address is binary 01 then straps four down to one.
// - Lowest address bit is internal and selects one of two port groups.
// - Straps latch at reset release or on supply good rising.
// - Low shed input starts switching off low-priority ports.
module pshc_top #(
  parameter int PORTS       = `PSHC_PORTS,
  parameter int RST_MIN_CYC = `PSHC_RST_MIN_CYC
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             device_reset_n,
  input  wire logic             priority_shed_n,
  input  wire logic             serial_clock,
  input  wire logic             serial_data_in,
  input  wire logic             mode_strap,
  input  wire logic             addr_strap_bit1,
  input  wire logic             addr_strap_bit2,
  input  wire logic             addr_strap_bit3,
  input  wire logic             addr_strap_bit4,
  input  wire logic             supply_good,
  input  wire logic [PORTS-1:0] port_fault,
  input  wire logic [PORTS-1:0] port_low_priority,
  input  wire logic [PORTS-1:0] port_power_req,
  output logic                  serial_data_out_oe,
  output logic                  interrupt_oe,
  output logic                  controller_enable,
  output logic                  host_mode,
  output logic [PORTS-1:0]      port_power_on,
  output logic                  group_valid,
  output logic                  group_select,
  output logic                  group_write,
  output logic [7:0]            group_data,
  output logic                  group_strobe
);
  localparam int CW = $clog2(RST_MIN_CYC + 1);

  typedef struct packed {
    pshc_pkg::pshc_state_t st;
    logic [CW-1:0] rcnt;
    logic          dev_rst;
    logic          scl_d;
    logic          sda_d;
    logic          busy;
    logic          sup_d;
    logic [3:0]    straps;
    logic          mode;
    logic [3:0]    bcnt;
    logic [7:0]    shift;
    logic          rw;
    logic          sda_oe;
    logic          int_oe;
    logic [PORTS-1:0] pwr;
    logic          gvalid;
    logic          gsel;
    logic          gwrite;
    logic [7:0]    gdata;
    logic          gstb;
    logic          ctrl_en;
  } pshc_top_t;

  pshc_top_t st_reg;
  pshc_top_t st_next;
  logic [9:0] pin_s;

  // Reset, shed, bus, strap and supply pins pass two flops first; port vectors do not
  pshc_sync #(
    .W (10)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     ({device_reset_n, priority_shed_n, serial_clock, serial_data_in,
                mode_strap, addr_strap_bit4, addr_strap_bit3, addr_strap_bit2,
                addr_strap_bit1, supply_good}),
    .dout    (pin_s)
  );

  wire r_n  = pin_s[9];
  wire shd  = pin_s[8];
  wire scl  = pin_s[7];
  wire sda  = pin_s[6];
  wire scl_rise = scl && !st_reg.scl_d;
  wire scl_fall = !scl && st_reg.scl_d;
  wire start_c  = scl && st_reg.scl_d && st_reg.sda_d && !sda;
  wire stop_c   = scl && st_reg.scl_d && !st_reg.sda_d && sda;

  // Address match against prefix and latched straps
  function automatic logic addr_hit(input logic [6:0] a, input logic [3:0] s);
    addr_hit = (a[6:5] == `PSHC_ADDR_PREFIX) && (a[4:1] == s);
  endfunction

  always_comb
  begin
    st_next       = st_reg;
    st_next.scl_d = scl;
    st_next.sda_d = sda;
    st_next.sup_d = pin_s[0];
    st_next.gstb  = 1'b0;
    // Reset accepted only after it is held long enough
    if (!r_n)
    begin
      if (st_reg.rcnt != CW'(RST_MIN_CYC))
        st_next.rcnt = st_reg.rcnt + CW'(1);
      else
        st_next.dev_rst = 1'b1;
    end
    else
    begin
      st_next.rcnt    = '0;
      st_next.dev_rst = 1'b0;
    end
    // Straps caught on release or supply good rising
    if ((st_reg.dev_rst && r_n) || (pin_s[0] && !st_reg.sup_d))
    begin
      st_next.straps = pin_s[4:1];
      st_next.mode   = !pin_s[5];
    end
    // Power follows request; shed drops low-priority ports
    st_next.pwr = port_power_req & ~(shd ? '0 : port_low_priority);
    // Bus framing
    if (start_c)
    begin
      st_next.busy   = 1'b1;
      st_next.st     = pshc_pkg::PSHC_ADDR;
      st_next.bcnt   = 4'h0;
      st_next.sda_oe = 1'b0;
    end
    else if (stop_c)
    begin
      st_next.busy   = 1'b0;
      st_next.st     = pshc_pkg::PSHC_IDLE;
      st_next.sda_oe = 1'b0;
      st_next.gvalid = 1'b0;
    end
    else
    begin
      unique case (st_reg.st)
        pshc_pkg::PSHC_IDLE: ;
        pshc_pkg::PSHC_ADDR, pshc_pkg::PSHC_DATA:
        begin
          if (scl_rise)
          begin
            st_next.shift = {st_reg.shift[6:0], sda};
            st_next.bcnt  = st_reg.bcnt + 4'h1;
          end
          if (scl_fall && st_reg.bcnt == 4'h8)
          begin
            st_next.bcnt = 4'h0;
            if (st_reg.st == pshc_pkg::PSHC_ADDR)
            begin
              if (addr_hit(st_reg.shift[7:1], st_reg.straps))
              begin
                st_next.st     = pshc_pkg::PSHC_AACK;
                st_next.sda_oe = 1'b1;
                st_next.rw     = st_reg.shift[0];
                st_next.gvalid = 1'b1;
                st_next.gsel   = st_reg.shift[1];
                st_next.gwrite = !st_reg.shift[0];
              end
              else
                st_next.st = pshc_pkg::PSHC_SKIP;
            end
            else
            begin
              st_next.st     = pshc_pkg::PSHC_DACK;
              st_next.sda_oe = !st_reg.rw;
              st_next.gdata  = st_reg.shift;
              st_next.gstb   = !st_reg.rw;
            end
          end
        end
        pshc_pkg::PSHC_AACK, pshc_pkg::PSHC_DACK:
        begin
          // Reads return no data here; group logic answers
          if (scl_fall)
          begin
            st_next.sda_oe = 1'b0;
            st_next.st     = pshc_pkg::PSHC_DATA;
          end
        end
        pshc_pkg::PSHC_SKIP: ;
        default: st_next.st = pshc_pkg::PSHC_IDLE;
      endcase
    end
    // Interrupt only updated while bus idle, avoiding mid-frame glitches
    if (!st_reg.busy && !start_c)
      st_next.int_oe = |port_fault;
    // Held reset wipes everything except the counter, the reset flag, the pin history, straps and mode
    if (st_reg.dev_rst && !r_n)
    begin
      st_next.pwr    = '0;
      st_next.st     = pshc_pkg::PSHC_IDLE;
      st_next.sda_oe = 1'b0;
      st_next.int_oe = 1'b0;
      st_next.gvalid = 1'b0;
      st_next.busy   = 1'b0;
      st_next.gsel   = 1'b0;
      st_next.gwrite = 1'b0;
      st_next.gdata  = 8'h00;
      st_next.gstb   = 1'b0;
      st_next.shift  = 8'h00;
      st_next.bcnt   = 4'h0;
      st_next.rw     = 1'b0;
    end
    // Enable kept in its own flop so the pin never passes an inverter
    st_next.ctrl_en = !st_next.dev_rst;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_reg        <= '0;
      st_reg.scl_d  <= 1'b1;
      st_reg.sda_d  <= 1'b1;
      st_reg.sup_d  <= 1'b1;
      st_reg.ctrl_en <= 1'b1;
      st_reg.straps <= 4'hF;
    end
    else
      st_reg <= st_next;
  end

  assign serial_data_out_oe = st_reg.sda_oe;
  assign interrupt_oe       = st_reg.int_oe;
  assign controller_enable  = st_reg.ctrl_en;
  assign host_mode          = st_reg.mode;
  assign port_power_on      = st_reg.pwr;
  assign group_valid        = st_reg.gvalid;
  assign group_select       = st_reg.gsel;
  assign group_write        = st_reg.gwrite;
  assign group_data         = st_reg.gdata;
  assign group_strobe       = st_reg.gstb;

  property p_rst_off;
    @(posedge clk_sys) disable iff (rst)
    st_reg.dev_rst && !r_n |=> (port_power_on == '0) && !controller_enable;
  endproperty
  AST_RST_OFF: assert property (p_rst_off) else $error("ports on in reset");
  AST_CTRL_DIS: assert property (@(posedge clk_sys) disable iff (rst)
    !r_n && st_reg.rcnt == CW'(RST_MIN_CYC) |=> !controller_enable)
    else $error("controller on in reset");
  AST_CTRL_EN: assert property (@(posedge clk_sys) disable iff (rst)
    r_n |=> controller_enable) else $error("controller off after release");
  AST_INT_STABLE: assert property (@(posedge clk_sys) disable iff (rst)
    st_reg.busy && st_next.busy |=> $stable(interrupt_oe))
    else $error("interrupt moved mid frame");
  AST_INT_FAULT: assert property (@(posedge clk_sys) disable iff (rst)
    !st_reg.busy && !start_c && !st_reg.dev_rst && |port_fault |=> interrupt_oe)
    else $error("fault not flagged");
  AST_SHED: assert property (@(posedge clk_sys) disable iff (rst)
    !shd && !st_reg.dev_rst |=> (port_power_on & $past(port_low_priority)) == '0)
    else $error("low priority port kept");
  AST_STRAP: assert property (@(posedge clk_sys) disable iff (rst)
    st_reg.dev_rst && r_n |=> st_reg.straps == $past(pin_s[4:1]))
    else $error("straps not latched");
  AST_MODE: assert property (@(posedge clk_sys) disable iff (rst)
    st_reg.dev_rst && r_n |=> host_mode == !$past(pin_s[5]))
    else $error("mode wrong");
  sequence s_addr_done;
    st_reg.st == pshc_pkg::PSHC_ADDR && scl_fall && st_reg.bcnt == 4'h8 && !start_c && !stop_c;
  endsequence
  AST_ACK: assert property (@(posedge clk_sys) disable iff (rst)
    s_addr_done ##0 addr_hit(st_reg.shift[7:1], st_reg.straps) && !(st_reg.dev_rst && !r_n)
    |=> serial_data_out_oe && group_valid && group_select == $past(st_reg.shift[1]))
    else $error("address ack wrong");
  AST_NACK: assert property (@(posedge clk_sys) disable iff (rst)
    s_addr_done ##0 (st_reg.shift[7:6] != 2'h1) |=> !serial_data_out_oe)
    else $error("bad prefix acked");
endmodule

// file: pshc_host_model.sv
`timescale 1ns/1ps
// Host on the serial bus; its clock idles high between frames
module pshc_host_model (
  input  wire logic clk_sys,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_drv
);
  // Idle bus: both lines released high
  initial
  begin
    scl = 1'h1;
    sda_drv = 1'h1;
  end
  // Half of the 32 ns link period, stepped on falling edges
  task automatic half();
    repeat (4) @(negedge clk_sys);
  endtask
  // Eight bits then a ninth clock; ack is read while clock is high
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sda_drv = b[i];
      half();
      scl = 1'h1;
      half();
      scl = 1'h0;
    end
    sda_drv = 1'h1;
    half();
    scl = 1'h1;
    ack = ~sda_wire;
    half();
    scl = 1'h0;
  endtask
  // Start, address byte, one data byte, stop
  task automatic frame(input logic [7:0] a, input logic [7:0] d,
                       output logic aa, output logic da);
    half();
    sda_drv = 1'h0;
    half();
    scl = 1'h0;
    put_byte(a, aa);
    put_byte(d, da);
    sda_drv = 1'h0;
    half();
    scl = 1'h1;
    half();
    sda_drv = 1'h1;
    half();
  endtask
endmodule

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk_sys, rst, rst_n, shed_n, mode_strap, supply_good;
  logic [4:1] strap;
  logic [7:0] fault, lowp, req, pwr, gdata, got_data;
  logic scl, sda, oe, int_oe, en, hmode, gvalid, gsel, gwr, gstb, got_sel, aa, da;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n_strobe = 0;
  // Open-drain data line, joined in and out as on a plain bus
  wire logic sda_in = sda & ~oe;
  pshc_host_model host (.clk_sys(clk_sys), .sda_wire(sda_in), .scl(scl), .sda_drv(sda));
  pshc_top #(.RST_MIN_CYC(8)) dut (
    .clk_sys(clk_sys), .rst(rst), .device_reset_n(rst_n), .priority_shed_n(shed_n),
    .serial_clock(scl), .serial_data_in(sda_in), .mode_strap(mode_strap),
    .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]), .addr_strap_bit3(strap[3]),
    .addr_strap_bit4(strap[4]), .supply_good(supply_good), .port_fault(fault),
    .port_low_priority(lowp), .port_power_req(req), .serial_data_out_oe(oe),
    .interrupt_oe(int_oe), .controller_enable(en), .host_mode(hmode),
    .port_power_on(pwr), .group_valid(gvalid), .group_select(gsel),
    .group_write(gwr), .group_data(gdata), .group_strobe(gstb));
  // 4 ns system clock
  initial
  begin
    clk_sys = 1'h0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Record each written byte as it is handed over
  always @(posedge clk_sys)
    if (gstb === 1'h1)
    begin
      n_strobe <= n_strobe + 1;
      got_data <= gdata;
      got_sel <= gsel;
    end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Long pulse is taken, short one ignored; straps and mode latch on release
  task automatic t_reset();
    for (int m = 1; m >= 0; m--)
    begin
      mode_strap = m[0];
      rst_n = 1'h0;
      wait_n(20);
      check("enable in reset", {7'h0, en}, 8'h00);
      check("ports in reset", pwr, 8'h00);
      rst_n = 1'h1;
      wait_n(8);
      check("mode", {7'h0, hmode}, {7'h0, ~m[0]});
      check("ports after", pwr, 8'hFF);
    end
    rst_n = 1'h0;
    wait_n(4);
    rst_n = 1'h1;
    wait_n(8);
    check("enable short pulse", {7'h0, en}, 8'h01);
    $display("t_reset done");
  endtask
  // Matching, group and mismatching addresses, then strap relatch before a write and a read address
  task automatic t_addr();
    logic [7:0] ab [7] = '{8'h6A, 8'h68, 8'hEA, 8'h6E, 8'h6A, 8'h54, 8'h55};
    logic [6:0] ok = 7'b1100111;
    logic w;
    int n;
    for (int i = 0; i < 7; i++)
    begin
      if (i == 4)
        strap = 4'h5;
      if (i == 5)
      begin
        supply_good = 1'h0;
        wait_n(4);
        supply_good = 1'h1;
      end
      n = n_strobe;
      w = ok[6-i] & ~ab[i][0];
      host.frame(ab[i], 8'hC3 ^ 8'(i), aa, da);
      wait_n(2);
      check("addr ack", {7'h0, aa}, {7'h0, ok[6-i]});
      check("data ack", {7'h0, da}, {7'h0, w});
      check("strobes", 8'(n_strobe - n), {7'h0, w});
      if (w)
      begin
        check("data", got_data, 8'hC3 ^ 8'(i));
        check("group", {7'h0, got_sel}, {7'h0, ab[i][1]});
      end
      if (ok[6-i])
      begin
        check("select", {7'h0, gsel}, {7'h0, ab[i][1]});
        check("write", {7'h0, gwr}, {7'h0, ~ab[i][0]});
      end
    end
    $display("t_addr done");
  endtask
  // Shed input drops only the low-priority ports
  task automatic t_shed();
    lowp = 8'h0F;
    req = 8'h3C;
    shed_n = 1'h0;
    wait_n(6);
    check("shed ports", pwr, 8'h30);
    shed_n = 1'h1;
    wait_n(6);
    check("restored ports", pwr, 8'h3C);
    req = 8'hFF;
    $display("t_shed done");
  endtask
  // Fault drives interrupt, but never inside a frame
  task automatic t_int();
    fault = 8'h04;
    wait_n(8);
    check("int on", {7'h0, int_oe}, 8'h01);
    fault = 8'h00;
    wait_n(8);
    check("int off", {7'h0, int_oe}, 8'h00);
    fork
      host.frame(8'h54, 8'h11, aa, da);
      begin
        wait_n(40);
        fault = 8'h10;
        wait_n(60);
        check("frame busy", {7'h0, gvalid}, 8'h01);
        check("int mid frame", {7'h0, int_oe}, 8'h00);
      end
    join
    wait_n(8);
    check("int after stop", {7'h0, int_oe}, 8'h01);
    fault = 8'h00;
    $display("t_int done");
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Watchdog well past the expected one and a half thousand cycles
  initial
  begin
    repeat (30000) @(posedge clk_sys);
    n_mismatch++;
    close_out();
  end
  // Main sequence
  initial
  begin
    rst = 1'h1;
    rst_n = 1'h1;
    shed_n = 1'h1;
    mode_strap = 1'h0;
    supply_good = 1'h1;
    strap = 4'hA;
    fault = 8'h00;
    lowp = 8'h00;
    req = 8'hFF;
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'h0;
    wait_n(4);
    t_reset();
    t_addr();
    t_shed();
    t_int();
    close_out();
  end
endmodule
